//--- design/lfo_pkg.sv
package lfo_pkg;
    // channel count and image layout
    localparam int NUM_CH = 8;
    localparam logic [7:0] OUT_IMAGE_OFS = 8'h00;
    localparam logic [7:0] OUT_IMAGE_RST = 8'h00;
    localparam logic [7:0] IN_AREA_DATA = 8'h00;

    // object dictionary addressing
    localparam logic [15:0] OBJ_IDX_CANOPEN = 16'h6200;
    localparam logic [15:0] OBJ_IDX_ECAT_BASE = 16'h7000;
    localparam logic [7:0] OBJ_SUB_FIRST = 8'h01;
    localparam logic [7:0] OBJ_SUB_LAST = 8'h08;

    // timing, clock at 125 MHz
    localparam int CLK_PERIOD_PS = 8000;
    localparam int LIMIT_TIME_US = 100;
    localparam int LIMIT_CYC = (LIMIT_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_CYC = FLASH_HALF_MS * 1000 * (1000000 / CLK_PERIOD_PS); // us times cycles per us
    localparam int LIM_CNT_W = 14;
    localparam int FLASH_CNT_W = 25;

    // state of the top-level module
    typedef struct packed {
        logic [7:0] img;
        logic [FLASH_CNT_W-1:0] flash_cnt;
        logic flash;
        logic [7:0] rdata;
        logic rack;
        logic rerr;
        logic obj_ack;
        logic obj_err;
        logic obj_rdata;
        logic run_led;
        logic mf_led;
        logic [7:0] do_led;
    } lfo_top_s;

    // state of the channel protection
    typedef struct packed {
        logic [NUM_CH-1:0] fault;
        logic [NUM_CH-1:0][LIM_CNT_W-1:0] lim_cnt;
    } lfo_prot_s;
endpackage : lfo_pkg

//--- design/lfo_protect.sv
`timescale 1ns/1ps
module lfo_protect
    import lfo_pkg::*;
#(
    parameter int LIMIT_CYCLES = lfo_pkg::LIMIT_CYC
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic pwr_sect_ok,
    input wire logic [lfo_pkg::NUM_CH-1:0] overload,
    input wire logic [lfo_pkg::NUM_CH-1:0] overtemp,
    output logic [lfo_pkg::NUM_CH-1:0] fault,
    output logic [lfo_pkg::NUM_CH-1:0] limit
);
    lfo_prot_s st_q;
    lfo_prot_s st_d;
    logic [NUM_CH-1:0] fault_d;
    logic [NUM_CH-1:0][LIM_CNT_W-1:0] cnt_d;
    localparam logic [LIM_CNT_W-1:0] LIM_LAST = LIM_CNT_W'(LIMIT_CYCLES - 1);

    // per channel: overtemp trips at once; overload limits first, trips once it outlasts the limit stage
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            always_comb
            begin
                cnt_d[g] = '0;
                fault_d[g] = st_q.fault[g];
                if (!pwr_sect_ok)
                begin
                    fault_d[g] = 1'b0;
                end
                else if (st_q.fault[g])
                begin
                    cnt_d[g] = '0;
                end
                else if (overtemp[g])
                begin
                    fault_d[g] = 1'b1;
                end
                else if (overload[g])
                begin
                    if (st_q.lim_cnt[g] == LIM_LAST)
                    begin
                        fault_d[g] = 1'b1;
                    end
                    else
                    begin
                        cnt_d[g] = st_q.lim_cnt[g] + 1'b1;
                    end
                end
            end
            // limiting only while still on; a tripped channel has no current to limit
            assign limit[g] = pwr_sect_ok & overload[g] & ~st_q.fault[g];
        end
    endgenerate

    // assemble next state
    always_comb
    begin
        st_d.fault = fault_d;
        st_d.lim_cnt = cnt_d;
    end

    // latches clear only on reset or power section off
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign fault = st_q.fault;

    chk_latch_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pwr_sect_ok && (fault != '0)) |=> ((fault & $past(fault)) == $past(fault)))
        else $error("latched fault cleared without supply cycle");
    chk_limit_before_trip: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pwr_sect_ok && overload[0] && !fault[0] && !overtemp[0]
            && st_q.lim_cnt[0] != LIM_LAST) |-> limit[0] ##1 !fault[0])
        else $error("channel tripped without limit stage");
    chk_trip_on_expiry: assert property (@(posedge clk_sys) disable iff (!nrst)
        (pwr_sect_ok && overload[0] && !fault[0] && st_q.lim_cnt[0] == LIM_LAST) |=> fault[0])
        else $error("overload outlasting limit did not trip");
endmodule : lfo_protect

//--- design/lfo_port.sv
// Operation
// - eight outputs, one per output bit
// - input area unused, reads return nothing
// - output byte at offset zero, bit per channel
// - CANopen index 6200h, subindex 01h-08h channels
// - EtherCAT index 7000h plus slot, same subindices
// - overload first limits current, channel stays on
// - persistent overload trips channel off, latched
// - latch clears only by power section cycle or reset
// - fault indicator shows stored fault status
// - fault lit only while channel commanded one, except lit on bus power failure and flashing on configuration error
// - green channel indicator follows commanded bit, dark on bus power failure
// - module error shown in every bus state except bus power failure, where the indicator is lit, and configuration error, where it flashes
// - indicators distinguish communication lost from good
// - distinct indicator state on bus power failure
// - indicators flash on configuration error
`timescale 1ns/1ps
module lfo_port
    import lfo_pkg::*;
#(
    parameter int LIMIT_CYCLES = lfo_pkg::LIMIT_CYC,
    parameter int FLASH_CYCLES = lfo_pkg::FLASH_CYC
)
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic BUS_IN_AREA,
    input wire logic [7:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    output logic [7:0] BUS_RDATA,
    output logic BUS_RACK,
    output logic BUS_RERR,
    input wire logic OBJ_REQ,
    input wire logic OBJ_WR,
    input wire logic OBJ_ECAT,
    input wire logic [7:0] OBJ_SLOT,
    input wire logic [15:0] OBJ_INDEX,
    input wire logic [7:0] OBJ_SUBINDEX,
    input wire logic OBJ_WDATA,
    output logic OBJ_RDATA,
    output logic OBJ_ACK,
    output logic OBJ_ERR,
    input wire logic PWR_SECT_OK,
    input wire logic [lfo_pkg::NUM_CH-1:0] CH_OVERLOAD,
    input wire logic [lfo_pkg::NUM_CH-1:0] CH_OVERTEMP,
    output logic [lfo_pkg::NUM_CH-1:0] CH_DRIVE,
    output logic [lfo_pkg::NUM_CH-1:0] CH_LIMIT,
    input wire logic BUS_COMM_OK,
    input wire logic BUS_PWR_OK,
    input wire logic CFG_ERR,
    output logic RUN_LED,
    output logic MODULE_FAULT_INDICATOR,
    output logic [lfo_pkg::NUM_CH-1:0] DO_LED
);
    lfo_top_s st_q;
    lfo_top_s st_d;
    logic [NUM_CH-1:0] fault;
    logic [15:0] obj_idx_exp;
    logic obj_idx_ok;
    logic obj_sub_ok;
    logic [2:0] obj_ch;
    logic mf_raw;
    localparam logic [FLASH_CNT_W-1:0] FLASH_LAST = FLASH_CNT_W'(FLASH_CYCLES - 1);

    // latched protection per channel
    lfo_protect #(
        .LIMIT_CYCLES(LIMIT_CYCLES)
    ) u_protect (
        .clk_sys(CLK_SYS),
        .nrst(NRST),
        .pwr_sect_ok(PWR_SECT_OK),
        .overload(CH_OVERLOAD),
        .overtemp(CH_OVERTEMP),
        .fault(fault),
        .limit(CH_LIMIT)
    );

    // object address decode; ethercat index moves with the slot
    always_comb
    begin
        if (OBJ_ECAT)
        begin
            obj_idx_exp = OBJ_IDX_ECAT_BASE + {8'h00, OBJ_SLOT};
        end
        else
        begin
            obj_idx_exp = OBJ_IDX_CANOPEN;
        end
        obj_idx_ok = (OBJ_INDEX == obj_idx_exp);
        obj_sub_ok = (OBJ_SUBINDEX >= OBJ_SUB_FIRST) && (OBJ_SUBINDEX <= OBJ_SUB_LAST);
        obj_ch = 3'(OBJ_SUBINDEX - OBJ_SUB_FIRST);
        mf_raw = |(fault & st_q.img);
    end

    // next state: image, answers, indicators
    always_comb
    begin
        st_d = st_q;
        st_d.rack = 1'b0;
        st_d.rerr = 1'b0;
        st_d.rdata = IN_AREA_DATA;
        st_d.obj_ack = 1'b0;
        st_d.obj_err = 1'b0;
        // object writes go first so a same-cycle byte write overrides them
        if (OBJ_REQ)
        begin
            st_d.obj_ack = 1'b1;
            if (obj_idx_ok && obj_sub_ok)
            begin
                st_d.obj_rdata = st_q.img[obj_ch];
                if (OBJ_WR)
                begin
                    st_d.img[obj_ch] = OBJ_WDATA;
                end
            end
            else
            begin
                st_d.obj_err = 1'b1;
            end
        end
        if (BUS_WR && !BUS_IN_AREA && BUS_ADDR == OUT_IMAGE_OFS)
        begin
            st_d.img = BUS_WDATA;
        end
        if (BUS_RD)
        begin
            st_d.rack = 1'b1;
            if (BUS_IN_AREA || BUS_ADDR != OUT_IMAGE_OFS)
            begin
                st_d.rerr = 1'b1;
            end
            else
            begin
                st_d.rdata = st_q.img;
            end
        end
        // free-running flash timebase
        if (st_q.flash_cnt == FLASH_LAST)
        begin
            st_d.flash_cnt = '0;
            st_d.flash = ~st_q.flash;
        end
        else
        begin
            st_d.flash_cnt = st_q.flash_cnt + 1'b1;
        end
        // indicator combinations; fault shown in every bus state except bus power failure, where it is lit, and configuration error, where it flashes
        st_d.do_led = st_q.img;
        st_d.mf_led = mf_raw;
        st_d.run_led = 1'b1;
        if (!BUS_PWR_OK)
        begin
            st_d.run_led = 1'b0;
            st_d.mf_led = 1'b1;
            st_d.do_led = '0;
        end
        else if (CFG_ERR)
        begin
            st_d.run_led = st_q.flash;
            st_d.mf_led = st_q.flash;
        end
        else if (!BUS_COMM_OK)
        begin
            st_d.run_led = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            st_q <= '0;
            st_q.img <= OUT_IMAGE_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // drive is gated by the latch every cycle, no register in between
    assign CH_DRIVE = st_q.img & ~fault;
    assign BUS_RDATA = st_q.rdata;
    assign BUS_RACK = st_q.rack;
    assign BUS_RERR = st_q.rerr;
    assign OBJ_RDATA = st_q.obj_rdata;
    assign OBJ_ACK = st_q.obj_ack;
    assign OBJ_ERR = st_q.obj_err;
    assign RUN_LED = st_q.run_led;
    assign MODULE_FAULT_INDICATOR = st_q.mf_led;
    assign DO_LED = st_q.do_led;

    chk_drive_gated: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_WR && !BUS_IN_AREA && BUS_ADDR == OUT_IMAGE_OFS) |=>
            (CH_DRIVE == ($past(BUS_WDATA) & ~fault)))
        else $error("drive not command masked by fault");
    chk_byte_write: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_WR && !BUS_IN_AREA && BUS_ADDR == OUT_IMAGE_OFS) ##1 BUS_RD && BUS_ADDR == OUT_IMAGE_OFS
            && !BUS_IN_AREA && !BUS_WR && !OBJ_REQ |=> BUS_RACK && BUS_RDATA == $past(BUS_WDATA, 2))
        else $error("output byte readback mismatch");
    chk_in_area_empty: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_RD && BUS_IN_AREA) |=> (BUS_RACK && BUS_RERR && BUS_RDATA == IN_AREA_DATA))
        else $error("input area returned data");
    chk_canopen_bit: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (OBJ_REQ && OBJ_WR && !OBJ_ECAT && OBJ_INDEX == OBJ_IDX_CANOPEN
            && OBJ_SUBINDEX == OBJ_SUB_FIRST && !BUS_WR) |=> OBJ_ACK && !OBJ_ERR
            && st_q.img[0] == $past(OBJ_WDATA))
        else $error("canopen subindex 01h did not reach channel 0");
    chk_ecat_bad_idx: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (OBJ_REQ && OBJ_ECAT && OBJ_INDEX != OBJ_IDX_ECAT_BASE + {8'h00, OBJ_SLOT}) |=> OBJ_ERR)
        else $error("wrong ethercat index accepted");
    chk_mf_stored: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_PWR_OK && !CFG_ERR) |=> (MODULE_FAULT_INDICATOR == |($past(fault) & $past(st_q.img))))
        else $error("fault indicator not stored fault of commanded channel");
    chk_do_led: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        BUS_PWR_OK |=> (DO_LED == $past(st_q.img)))
        else $error("channel indicator not following command");
    chk_comm_lost: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_PWR_OK && !CFG_ERR && !BUS_COMM_OK) ##1 !BUS_COMM_OK |-> !RUN_LED)
        else $error("run indicator lit without communication");
    chk_pwr_fail: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !BUS_PWR_OK |=> (!RUN_LED && MODULE_FAULT_INDICATOR && DO_LED == '0))
        else $error("bus power failure not shown");

    // bus read answers pulse one cycle after each read strobe
    chk_rack_follows: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        1'b1 |=> (BUS_RACK == $past(BUS_RD)))
        else $error("read answer not one cycle after strobe");

    // read data returns to the idle value outside answers
    chk_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        !BUS_RD |=> (BUS_RDATA == IN_AREA_DATA))
        else $error("read data not idle outside an answer");

    // a read of the output byte returns the image without error
    chk_rdata_img: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_RD && !BUS_IN_AREA && BUS_ADDR == OUT_IMAGE_OFS)
            |=> (!BUS_RERR && BUS_RDATA == $past(st_q.img)))
        else $error("output byte read did not return the image");

    // unmapped offsets answer with an error
    chk_unmapped_err: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_RD && !BUS_IN_AREA && BUS_ADDR != OUT_IMAGE_OFS) |=> (BUS_RACK && BUS_RERR))
        else $error("unmapped read answered without error");

    // writes outside the output byte leave the image alone
    chk_write_ignored: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_WR && (BUS_IN_AREA || BUS_ADDR != OUT_IMAGE_OFS) && !OBJ_REQ)
            |=> (st_q.img == $past(st_q.img)))
        else $error("write outside output byte changed image");

    // every object request is answered once, one cycle later
    chk_obj_ack: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        1'b1 |=> (OBJ_ACK == $past(OBJ_REQ)))
        else $error("object answer not one cycle after request");

    // subindex outside 01h..08h is refused and changes nothing
    chk_obj_bad_sub: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (OBJ_REQ && !BUS_WR && (OBJ_SUBINDEX < OBJ_SUB_FIRST || OBJ_SUBINDEX > OBJ_SUB_LAST))
            |=> (OBJ_ERR && st_q.img == $past(st_q.img)))
        else $error("subindex outside range accepted");

    // ethercat read of subindex 01h returns channel 0
    chk_ecat_read: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (OBJ_REQ && !OBJ_WR && OBJ_ECAT && OBJ_SUBINDEX == OBJ_SUB_FIRST
            && OBJ_INDEX == OBJ_IDX_ECAT_BASE + {8'h00, OBJ_SLOT})
            |=> (!OBJ_ERR && OBJ_RDATA == $past(st_q.img[0])))
        else $error("ethercat subindex 01h did not read channel 0");

    // image changes only through a write or an object access
    chk_img_holds: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (!BUS_WR && !OBJ_REQ) |=> (st_q.img == $past(st_q.img)))
        else $error("output byte changed without a write");

    // limiting shows only on live channels of a powered section
    chk_limit_live: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (CH_LIMIT == (CH_OVERLOAD & ~fault & {NUM_CH{PWR_SECT_OK}})))
        else $error("limit flag disagrees with overload and latch");

    // byte and latches are clear on the first edge after reset
    chk_reset_clear: assert property (@(posedge CLK_SYS)
        (!NRST ##1 NRST) |-> (st_q.img == OUT_IMAGE_RST && fault == '0 && CH_DRIVE == '0))
        else $error("reset left output byte or latches set");

    // run lit whenever bus, power and configuration are good
    chk_run_good: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_PWR_OK && !CFG_ERR && BUS_COMM_OK) |=> RUN_LED)
        else $error("run indicator dark with good communication");

    // configuration error flashes run and fault together
    chk_cfg_flash: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_PWR_OK && CFG_ERR) |=> (RUN_LED == MODULE_FAULT_INDICATOR))
        else $error("indicators not flashing together on configuration error");

    // a stored fault stays visible with communication lost
    chk_mf_comm_lost: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        (BUS_PWR_OK && !CFG_ERR && !BUS_COMM_OK && (fault & st_q.img) != '0)
            |=> MODULE_FAULT_INDICATOR)
        else $error("fault indicator dark with communication lost");
endmodule : lfo_port

//--- verif/lfo_head.sv
`timescale 1ns/1ps
// backplane bus head: relays controller bytes to the module
module lfo_head (
    input wire logic clk,
    output logic wr,
    output logic rd,
    output logic in_area,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rack,
    input wire logic rerr
);
    initial {wr, rd, in_area, addr, wdata} = '0;

    // one-cycle write strobe; data inverted after so stale bytes never match
    task automatic put(input logic ia, input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1;
        {wr, in_area, addr, wdata} = {1'b1, ia, a, v};
        @(posedge clk);
        #1;
        wr = 1'b0;
        wdata = ~v;
    endtask : put

    // one-cycle read strobe; answer sampled the cycle after it is taken
    task automatic get(input logic ia, input logic [7:0] a, output logic [7:0] v,
        output logic [1:0] r);
        @(posedge clk);
        #1;
        {rd, in_area, addr} = {1'b1, ia, a};
        @(posedge clk);
        #1;
        rd = 1'b0;
        v = rdata;
        r = {rack, rerr};
    endtask : get

    // write then read back in the very next cycle, no idle edge between
    task automatic put_get(input logic [7:0] v, output logic [7:0] rv, output logic [1:0] r);
        @(posedge clk);
        #1;
        {wr, rd, in_area, addr, wdata} = {1'b1, 1'b0, 1'b0, 8'h00, v};
        @(posedge clk);
        #1;
        {wr, rd, wdata} = {1'b0, 1'b1, ~v};
        @(posedge clk);
        #1;
        rd = 1'b0;
        rv = rdata;
        r = {rack, rerr};
    endtask : put_get
endmodule : lfo_head

//--- verif/lfo_port_tb_top.sv
`timescale 1ns/1ps
module lfo_port_tb_top;
    import lfo_pkg::*;
    logic CLK_SYS, NRST, BUS_WR, BUS_RD, BUS_IN_AREA, BUS_RACK, BUS_RERR;
    logic [7:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, OBJ_SLOT, OBJ_SUBINDEX;
    logic OBJ_REQ, OBJ_WR, OBJ_ECAT, OBJ_WDATA, OBJ_RDATA, OBJ_ACK, OBJ_ERR;
    logic [15:0] OBJ_INDEX;
    logic PWR_SECT_OK, BUS_COMM_OK, BUS_PWR_OK, CFG_ERR, RUN_LED, MODULE_FAULT_INDICATOR;
    logic [7:0] CH_OVERLOAD, CH_OVERTEMP, CH_DRIVE, CH_LIMIT, DO_LED;
    logic [7:0] img, flt, d;
    logic [1:0] r;
    logic [31:0] seed = 32'h5e64;
    int bad_count, samples_checked, cyc, i, n;

    lfo_port #(.LIMIT_CYCLES(8), .FLASH_CYCLES(4)) u_dut (.CLK_SYS, .NRST, .BUS_WR,
        .BUS_RD, .BUS_IN_AREA, .BUS_ADDR, .BUS_WDATA, .BUS_RDATA, .BUS_RACK, .BUS_RERR,
        .OBJ_REQ, .OBJ_WR, .OBJ_ECAT, .OBJ_SLOT, .OBJ_INDEX, .OBJ_SUBINDEX, .OBJ_WDATA,
        .OBJ_RDATA, .OBJ_ACK, .OBJ_ERR, .PWR_SECT_OK, .CH_OVERLOAD, .CH_OVERTEMP,
        .CH_DRIVE, .CH_LIMIT, .BUS_COMM_OK, .BUS_PWR_OK, .CFG_ERR, .RUN_LED,
        .MODULE_FAULT_INDICATOR, .DO_LED);
    lfo_head u_head (.clk(CLK_SYS), .wr(BUS_WR), .rd(BUS_RD), .in_area(BUS_IN_AREA),
        .addr(BUS_ADDR), .wdata(BUS_WDATA), .rdata(BUS_RDATA), .rack(BUS_RACK),
        .rerr(BUS_RERR));

    // 125 MHz
    initial
    begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : xs

    task automatic chk(input string t, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", t, e, g);
        end
    endtask : chk

    // object access; answer sampled once the ack cycle has settled
    task automatic obj(input logic w, input logic ec, input logic [15:0] ix,
        input logic [7:0] sx, input logic b);
        @(posedge CLK_SYS);
        #1;
        {OBJ_REQ, OBJ_WR, OBJ_ECAT, OBJ_INDEX, OBJ_SUBINDEX, OBJ_WDATA} = {2'b11 & {1'b1, w},
            ec, ix, sx, b};
        @(posedge CLK_SYS);
        #1;
        OBJ_REQ = 1'b0;
        r = {OBJ_ACK, OBJ_ERR};
    endtask : obj

    // leds trail inputs by one cycle, so compare one edge later
    task automatic look(input string t);
        @(posedge CLK_SYS);
        #1;
        chk({t, " drive"}, img & ~flt, CH_DRIVE);
        chk({t, " do_led"}, BUS_PWR_OK ? img : 8'h00, DO_LED);
        chk({t, " mf"}, {7'h0, !BUS_PWR_OK || |(img & flt)}, {7'h0, MODULE_FAULT_INDICATOR});
        chk({t, " run"}, {7'h0, BUS_PWR_OK && BUS_COMM_OK}, {7'h0, RUN_LED});
    endtask : look

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge CLK_SYS)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    initial
    begin
        {OBJ_REQ, OBJ_WR, OBJ_ECAT, OBJ_WDATA, CFG_ERR, CH_OVERLOAD, CH_OVERTEMP} = '0;
        {PWR_SECT_OK, BUS_COMM_OK, BUS_PWR_OK, OBJ_INDEX, OBJ_SUBINDEX} = {3'b111, 24'h0};
        OBJ_SLOT = xs();
        {NRST, img, flt} = '0;
        repeat (4) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        look("reset");
        u_head.get(1'b0, 8'h00, d, r);
        chk("reset byte", 8'h00, d);
        $display("test reset done");
        for (i = 0; i < 6; i++)
        begin
            img = xs();
            u_head.put_get(img, d, r);
            chk("byte", img, d);
            chk("rack", 8'h2, {6'h0, r});
            look("byte");
        end
        u_head.get(1'b1, 8'h00, d, r);
        chk("in area", 8'h03, {d[5:0], r});
        u_head.get(1'b0, 8'h01, d, r);
        chk("unmapped", 8'h03, {d[5:0], r});
        u_head.put(1'b0, 8'h01, ~img);
        u_head.put(1'b1, 8'h00, ~img);
        look("ignored");
        $display("test byte bus done");
        for (i = 0; i < 8; i++)
        begin
            obj(1'b1, 1'b0, 16'h6200, 8'(i + 1), ~img[i]);
            img[i] = ~img[i];
            chk("obj ack", 8'h2, {6'h0, r});
            obj(1'b0, 1'b1, 16'h7000 + 16'(OBJ_SLOT), 8'(i + 1), 1'b0);
            chk("obj rd", {7'h0, img[i]}, {7'h0, OBJ_RDATA});
        end
        obj(1'b1, 1'b0, 16'h6201, 8'h01, ~img[0]);
        chk("bad index", 8'h3, {6'h0, r});
        obj(1'b1, 1'b1, 16'h7000 + 16'(OBJ_SLOT), 8'h09, ~img[0]);
        chk("bad sub", 8'h3, {6'h0, r});
        obj(1'b1, 1'b0, 16'h6200, 8'h00, ~img[0]);
        chk("zero sub", 8'h3, {6'h0, r});
        obj(1'b0, 1'b1, 16'h7001 + 16'(OBJ_SLOT), 8'h01, 1'b0);
        chk("bad ecat index", 8'h3, {6'h0, r});
        look("object");
        $display("test object done");
        img = 8'hFF;
        u_head.put(1'b0, 8'h00, img);
        CH_OVERLOAD = 8'h08;
        #1;
        chk("limit", 8'h08, CH_LIMIT);
        repeat (7) look("limiting");
        flt = 8'h08;
        @(posedge CLK_SYS);
        #1;
        chk("trip edge", img & ~flt, CH_DRIVE);
        chk("limit off", 8'h00, CH_LIMIT);
        look("tripped");
        CH_OVERLOAD = 8'h00;
        img = 8'hF7;
        u_head.put(1'b0, 8'h00, img);
        look("cmd off");
        img = 8'hFF;
        u_head.put(1'b0, 8'h00, img);
        look("still off");
        CH_OVERTEMP = 8'h20;
        @(posedge CLK_SYS);
        #1;
        CH_OVERTEMP = 8'h00;
        flt = 8'h28;
        look("overtemp");
        BUS_COMM_OK = 1'b0;
        look("comm lost");
        BUS_PWR_OK = 1'b0;
        look("bus power");
        {BUS_PWR_OK, BUS_COMM_OK, CFG_ERR} = 3'b111;
        n = 0;
        @(posedge CLK_SYS);
        #1;
        d[0] = RUN_LED;
        repeat (12)
        begin
            @(posedge CLK_SYS);
            #1;
            n += int'(RUN_LED !== d[0]);
            d[0] = RUN_LED;
        end
        chk("flash", 8'h1, {7'h0, n >= 2});
        CFG_ERR = 1'b0;
        PWR_SECT_OK = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        PWR_SECT_OK = 1'b1;
        flt = 8'h00;
        look("power cycle");
        CH_OVERTEMP = 8'h01;
        @(posedge CLK_SYS);
        #1;
        {CH_OVERTEMP, NRST, img, flt} = '0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        look("mid reset");
        $display("test protection done");
        end_of_test();
    end
endmodule : lfo_port_tb_top
